// file: src/hpp_regs.svh
// register offsets, field positions, reset values and timing counts of the host byte port
`ifndef HPP_REGS_SVH
`define HPP_REGS_SVH

// processor side register indices on the plain register port
`define REG_CTRL       3'h0
`define REG_CPU_ADDR   3'h1
`define REG_CPU_WDATA  3'h2
`define REG_CPU_RDATA  3'h3
`define REG_IRQ_STATUS 3'h4
`define REG_IRQ_CLEAR  3'h5
`define REG_IRQ_ENABLE 3'h6

// control register fields, shared by host and processor
`define CTRL_BOB_BIT   0
`define CTRL_REQ_BIT   1
`define CTRL_HIRQ_BIT  2
`define CTRL_BUSY_BIT  3
`define CTRL_BOB_RST   1'b0

// interrupt status fields
`define IRQ_HOSTREQ_BIT 0
`define IRQ_MEMDONE_BIT 1
`define IRQ_W           2

// access select codes on the two select pins {high, low}
`define SEL_CTRL     2'h0
`define SEL_DATA_INC 2'h1
`define SEL_PTR      2'h2
`define SEL_DATA     2'h3

// least processor clocks per host byte, start to start
`define PORT_BYTE_CYCLES 5
`define BUSY_LOAD        3'(`PORT_BYTE_CYCLES - 3)

`endif

// file: src/host_port_pkg.sv
// types of the host byte port
package host_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_HOLD = 2'b10
  } port_state_t;

endpackage : host_port_pkg

// file: src/mem_req_if.sv
// word access port between the port logic and the shared memory
`timescale 1ns/100ps
`default_nettype none

interface mem_req_if #(
  parameter int AW = 11,
  parameter int DW = 16
);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          we;
  logic [DW-1:0] rdata;

  modport requester (output addr, output wdata, output we, input rdata);
  modport storage   (input addr, input wdata, input we, output rdata);
endinterface : mem_req_if

`default_nettype wire

// file: src/pin_sync.sv
// two flip-flop synchroniser for a vector of pins
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] stage_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage_q <= '0;
      pinOut  <= '0;
    end else begin
      stage_q <= pinIn;
      pinOut  <= stage_q;
    end
  end
endmodule : pin_sync

`default_nettype wire

// file: src/shared_word_mem.sv
// shared word memory in flip-flops, one port
`timescale 1ns/100ps
`default_nettype none

module shared_word_mem #(
  parameter int AW = 11,
  parameter int DW = 16
) (
  input  wire logic  sys_clk,
  mem_req_if.storage port
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // read is combinational from the index
  assign port.rdata = mem[port.addr];

  // write on the clock edge
  always_ff @(posedge sys_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end
endmodule : shared_word_mem

`default_nettype wire

// file: src/host_byte_port_access.sv
// host byte port: eight-bit host bus into shared word memory, control and interrupts
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "hpp_regs.svh"

module host_byte_port_access #(
  parameter int ADDR_W = 11
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  hostByteBusIn,
  output logic      [7:0]  hostByteBusOut,
  output logic             hostByteBusOe,
  input  wire logic        bytePositionFlag,
  input  wire logic        accessSelectLow,
  input  wire logic        accessSelectHigh,
  input  wire logic        hostReadWriteSel,
  input  wire logic        addrStrobeN,
  input  wire logic        portSelectN,
  input  wire logic        dataStrobeOne,
  input  wire logic        dataStrobeTwo,
  output logic             hostWaitReady,
  output logic             hostIrqOut,
  input  wire logic        cpuInReset,
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [15:0] regRdData,
  output logic             cpuIrq
);
  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [16:0] pinRaw;
  logic [16:0] pinSync;
  // processor reset passes inverted so the synchroniser's reset state reads as in reset
  assign pinRaw = {~cpuInReset, hostByteBusIn, bytePositionFlag, accessSelectHigh,
                   accessSelectLow, hostReadWriteSel, addrStrobeN, portSelectN,
                   dataStrobeOne, dataStrobeTwo};

  pin_sync #(.W(17)) pinSyncInst (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pinIn   (pinRaw),
    .pinOut  (pinSync)
  );

  logic       cpuRstS;
  logic [7:0] busS;
  logic [3:0] ctlS;
  logic       asS;
  logic       csS;
  logic       strobeOn;
  assign cpuRstS = ~pinSync[16];
  assign busS    = pinSync[15:8];
  assign ctlS    = pinSync[7:4];   // flag, select high, select low, read/write
  assign asS     = pinSync[3];
  assign csS     = pinSync[2];
  // combined strobe active when the exclusive-NOR of the two is low
  assign strobeOn = ~csS & ~(pinSync[1] ~^ pinSync[0]);

  // ****************************************************
  // shared memory
  // ****************************************************
  mem_req_if #(.AW(ADDR_W), .DW(16)) memIf ();

  shared_word_mem #(.AW(ADDR_W), .DW(16)) memInst (
    .sys_clk (sys_clk),
    .port    (memIf.storage)
  );

  // ****************************************************
  // state
  // ****************************************************
  host_port_pkg::port_state_t state_q;
  logic [2:0]        busyCnt_q;
  logic              asPrev_q;
  logic              asUsed_q;
  logic [3:0]        ctlLat_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [15:0]       wordHold_q;
  logic [15:0]       readWord_q;
  logic              bob_q;
  logic              hostIrq_q;
  logic [ADDR_W-1:0] cpuAddr_q;
  logic [15:0]       cpuWData_q;
  logic [15:0]       cpuRData_q;
  logic              cpuPend_q;
  logic              cpuWr_q;
  logic [`IRQ_W-1:0] irqStatus_q;
  logic [`IRQ_W-1:0] irqEnable_q;

  // ****************************************************
  // access decode
  // ****************************************************
  logic        start;
  logic [3:0]  curCtl;
  logic        isSecond;
  logic [1:0]  sel;
  logic        isRead;
  logic        hiHalf;
  logic        isData;
  logic        isInc;
  logic [15:0] fullWord;
  logic [15:0] srcWord;
  logic [15:0] ctrlWord;
  logic [7:0]  byteOut;
  logic        ctrlWrDone;
  logic        ptrWrDone;
  logic        hostMemRd;
  logic        hostMemWr;
  logic        hostMemUse;
  logic        cpuGo;

  assign start    = (state_q == host_port_pkg::ST_IDLE) && strobeOn;
  // strobe-time sample unless the address strobe already latched them
  assign curCtl   = asUsed_q ? ctlLat_q : ctlS;
  assign isSecond = curCtl[3];
  assign sel      = curCtl[2:1];
  assign isRead   = curCtl[0];
  assign isData   = (sel == `SEL_DATA) || (sel == `SEL_DATA_INC);
  assign isInc    = (sel == `SEL_DATA_INC);
  // the half carried by this byte depends on byte order and position
  assign hiHalf   = isSecond ^ bob_q;
  assign fullWord = hiHalf ? {busS, wordHold_q[7:0]} : {wordHold_q[15:8], busS};
  assign ctrlWord = {12'h000, cpuPend_q, hostIrq_q, irqStatus_q[`IRQ_HOSTREQ_BIT], bob_q};

  assign ctrlWrDone = start && !isRead && isSecond && (sel == `SEL_CTRL);
  assign ptrWrDone  = start && !isRead && isSecond && (sel == `SEL_PTR);
  assign hostMemRd  = start && isRead && !isSecond && isData;
  assign hostMemWr  = start && !isRead && isSecond && isData;
  assign hostMemUse = hostMemRd || hostMemWr;
  // processor access stands aside in any cycle the host uses memory
  assign cpuGo      = cpuPend_q && !hostMemUse;

  // word source for the first byte of a read
  always_comb begin
    srcWord = 16'h0000;
    if (sel == `SEL_CTRL) begin
      srcWord = ctrlWord;
    end else if (sel == `SEL_PTR) begin
      srcWord = {{(16-ADDR_W){1'b0}}, ptr_q};
    end else begin
      srcWord = memIf.rdata;
    end
  end

  // second byte of a read comes from the snapshot of the first
  always_comb begin
    if (isSecond) begin
      byteOut = hiHalf ? readWord_q[15:8] : readWord_q[7:0];
    end else begin
      byteOut = hiHalf ? srcWord[15:8] : srcWord[7:0];
    end
  end

  // memory port: host first, processor otherwise
  always_comb begin
    memIf.addr  = cpuAddr_q;
    memIf.wdata = cpuWData_q;
    memIf.we    = cpuGo && cpuWr_q;
    if (hostMemUse) begin
      // write with increment goes to the incremented pointer
      memIf.addr  = (hostMemWr && isInc) ? ADDR_W'(ptr_q + 1'b1) : ptr_q;
      memIf.wdata = fullWord;
      memIf.we    = hostMemWr;
    end
  end

  // ****************************************************
  // address strobe latch
  // ****************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      asPrev_q <= 1'b0; // matches the synchroniser's low reset state, no false fall
      asUsed_q <= 1'b0;
      ctlLat_q <= 4'h0;
    end else begin
      asPrev_q <= asS;
      if (asPrev_q && !asS) begin
        ctlLat_q <= ctlS;
        asUsed_q <= 1'b1;
      end else if (start) begin
        asUsed_q <= 1'b0;
      end
    end
  end

  // ****************************************************
  // byte sequencer, ready and bus drive
  // ****************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q        <= host_port_pkg::ST_IDLE;
      busyCnt_q      <= 3'h0;
      hostWaitReady  <= 1'b0;
      hostByteBusOe  <= 1'b0;
      hostByteBusOut <= 8'h00;
    end else begin
      case (state_q)
        host_port_pkg::ST_IDLE: begin
          if (strobeOn) begin
            state_q        <= host_port_pkg::ST_BUSY;
            busyCnt_q      <= `BUSY_LOAD;
            hostByteBusOut <= byteOut;
            hostByteBusOe  <= isRead;
          end
        end
        host_port_pkg::ST_BUSY: begin
          if (busyCnt_q == 3'h0) begin
            state_q       <= host_port_pkg::ST_HOLD;
            hostWaitReady <= 1'b1;
          end else begin
            busyCnt_q <= busyCnt_q - 3'h1;
          end
        end
        host_port_pkg::ST_HOLD: begin
          if (!strobeOn) begin
            state_q       <= host_port_pkg::ST_IDLE;
            hostWaitReady <= 1'b0;
            hostByteBusOe <= 1'b0;
          end
        end
        default: begin
          state_q <= host_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // word assembly and read snapshot
  // ****************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wordHold_q <= 16'h0000;
      readWord_q <= 16'h0000;
    end else if (start) begin
      if (!isRead && !isSecond) begin
        if (hiHalf) begin
          wordHold_q[15:8] <= busS;
        end else begin
          wordHold_q[7:0] <= busS;
        end
      end
      if (isRead && !isSecond) begin
        readWord_q <= srcWord;
      end
    end
  end

  // ****************************************************
  // address pointer
  // ****************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= '0;
    end else if (ptrWrDone) begin
      ptr_q <= fullWord[ADDR_W-1:0];
    end else if (start && isInc && isSecond) begin
      // read bumps after its word, write before its word
      ptr_q <= ADDR_W'(ptr_q + 1'b1);
    end
  end

  // ****************************************************
  // control register and host interrupt
  // ****************************************************
  logic cpuCtrlWr;
  assign cpuCtrlWr = regWrStb && (regAddr == `REG_CTRL);

  // byte order written by either side, host wins a tie
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bob_q <= `CTRL_BOB_RST;
    end else if (ctrlWrDone) begin
      bob_q <= fullWord[`CTRL_BOB_BIT];
    end else if (cpuCtrlWr) begin
      bob_q <= regWrData[`CTRL_BOB_BIT];
    end
  end

  // processor sets, host writes a one to clear; set wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hostIrq_q <= 1'b0;
    end else if (cpuCtrlWr && regWrData[`CTRL_HIRQ_BIT]) begin
      hostIrq_q <= 1'b1;
    end else if (ctrlWrDone && fullWord[`CTRL_HIRQ_BIT]) begin
      hostIrq_q <= 1'b0;
    end
  end

  // output forced high during processor reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hostIrqOut <= 1'b1;
    end else begin
      hostIrqOut <= cpuRstS | hostIrq_q;
    end
  end

  // ****************************************************
  // processor memory access
  // ****************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpuAddr_q  <= '0;
      cpuWData_q <= 16'h0000;
      cpuRData_q <= 16'h0000;
      cpuPend_q  <= 1'b0;
      cpuWr_q    <= 1'b0;
    end else begin
      if (cpuGo) begin
        cpuPend_q <= 1'b0;
        if (!cpuWr_q) begin
          cpuRData_q <= memIf.rdata;
        end
      end
      if (regWrStb && regAddr == `REG_CPU_ADDR) begin
        cpuAddr_q <= regWrData[ADDR_W-1:0]; // posts a read
        cpuPend_q <= 1'b1;
        cpuWr_q   <= 1'b0;
      end else if (regWrStb && regAddr == `REG_CPU_WDATA) begin
        cpuWData_q <= regWrData; // posts a write
        cpuPend_q  <= 1'b1;
        cpuWr_q    <= 1'b1;
      end
    end
  end

  // ****************************************************
  // processor interrupts
  // ****************************************************
  logic [`IRQ_W-1:0] irqEvent;
  logic [`IRQ_W-1:0] irqClear;
  assign irqEvent[`IRQ_HOSTREQ_BIT] = ctrlWrDone && fullWord[`CTRL_REQ_BIT];
  assign irqEvent[`IRQ_MEMDONE_BIT] = cpuGo;
  assign irqClear = (regWrStb && regAddr == `REG_IRQ_CLEAR) ? regWrData[`IRQ_W-1:0] : '0;

  // sticky status, an event in the clear cycle survives
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus_q <= '0;
      irqEnable_q <= '0;
      cpuIrq      <= 1'b0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~irqClear) | irqEvent;
      if (regWrStb && regAddr == `REG_IRQ_ENABLE) begin
        irqEnable_q <= regWrData[`IRQ_W-1:0];
      end
      cpuIrq <= |(irqStatus_q & irqEnable_q);
    end
  end

  // ****************************************************
  // register read port
  // ****************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 16'h0000;
    end else if (regRdStb) begin
      if (regAddr == `REG_CTRL) begin
        regRdData <= ctrlWord;
      end else if (regAddr == `REG_CPU_ADDR) begin
        regRdData <= {{(16-ADDR_W){1'b0}}, cpuAddr_q};
      end else if (regAddr == `REG_CPU_WDATA) begin
        regRdData <= cpuWData_q;
      end else if (regAddr == `REG_CPU_RDATA) begin
        regRdData <= cpuRData_q;
      end else if (regAddr == `REG_IRQ_STATUS) begin
        regRdData <= {{(16-`IRQ_W){1'b0}}, irqStatus_q};
      end else if (regAddr == `REG_IRQ_ENABLE) begin
        regRdData <= {{(16-`IRQ_W){1'b0}}, irqEnable_q};
      end else begin
        regRdData <= 16'h0000;
      end
    end else begin
      regRdData <= 16'h0000;
    end
  end

endmodule : host_byte_port_access

`default_nettype wire

// file: verif/host_byte_port_access_properties.sv
// checker of host byte port pin and register port timing
`timescale 1ns/100ps
`default_nettype none

module host_byte_port_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        hostByteBusOe,
  input wire logic        hostReadWriteSel,
  input wire logic        portSelectN,
  input wire logic        dataStrobeOne,
  input wire logic        dataStrobeTwo,
  input wire logic        hostWaitReady,
  input wire logic        hostIrqOut,
  input wire logic        cpuInReset,
  input wire logic [2:0]  regAddr,
  input wire logic        regRdStb,
  input wire logic [15:0] regRdData
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic strobeOn;

  // host strobe as seen at the pins
  assign strobeOn = !portSelectN && (dataStrobeOne ^ dataStrobeTwo);

  // register port and interrupt output
  read_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData == 16'h0)
    else $error("read data not zero outside read cycle");
  unmapped_read_a: assert property (
    regRdStb && (regAddr == 3'h5 || regAddr == 3'h7) |=> regRdData == 16'h0)
    else $error("unmapped or clear index read not zero");
  irq_in_reset_a: assert property (cpuInReset [*4] |-> hostIrqOut)
    else $error("host interrupt low while processor in reset");
  // ready and output enable against the host strobe
  ready_cause_a: assert property ($rose(hostWaitReady) |-> $past(strobeOn, 4))
    else $error("ready rose without a held strobe");
  ready_release_a: assert property ($fell(strobeOn) |-> ##[1:4] !hostWaitReady)
    else $error("ready not dropped after strobe release");
  byte_gap_a: assert property ($fell(hostWaitReady) |-> !hostWaitReady [*4])
    else $error("bytes closer than five clocks");
  oe_read_only_a: assert property ($rose(hostByteBusOe) |-> $past(hostReadWriteSel))
    else $error("bus driven on a write access");
  ready_with_oe_a: assert property (
    $rose(hostWaitReady) && hostReadWriteSel |-> hostByteBusOe)
    else $error("read completed without driving bus");
endmodule : host_byte_port_checker

bind host_byte_port_access host_byte_port_checker host_byte_port_checker_i (
  .sys_clk, .rstn, .hostByteBusOe, .hostReadWriteSel, .portSelectN, .dataStrobeOne,
  .dataStrobeTwo, .hostWaitReady, .hostIrqOut, .cpuInReset, .regAddr, .regRdStb,
  .regRdData
);

`default_nettype wire

// file: verif/host_bus_model.sv
// model of the external host on the byte bus
`timescale 1ns/100ps
`default_nettype none

module host_bus_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] busWire,
  input  wire logic       hostWaitReady,
  output logic      [7:0] drvData,
  output logic            drvOe,
  output logic            bytePositionFlag,
  output logic            accessSelectLow,
  output logic            accessSelectHigh,
  output logic            hostReadWriteSel,
  output logic            portSelectN,
  output logic            dataStrobeOne,
  output logic            dataStrobeTwo,
  output logic            addrStrobeN
);
  int   timeouts = 0;
  logic altStrobe = 1'b0; // active high strobe on second pin, first pin low
  logic useAs     = 1'b0; // controls latched by the address strobe

  // idle pins at time zero
  initial begin
    {drvData, drvOe, bytePositionFlag, accessSelectLow, accessSelectHigh} = '0;
    {hostReadWriteSel, portSelectN, dataStrobeOne, dataStrobeTwo, addrStrobeN} = 5'h1f;
  end

  // one byte: pins held from strobe start to the edge where ready is seen
  task automatic doByte(input logic [1:0] sel, input logic rd, input logic flag,
                        input logic [7:0] wb, output logic [7:0] rb);
    int n;
    @(posedge sys_clk);
    {accessSelectHigh, accessSelectLow} <= sel;
    hostReadWriteSel <= rd;
    bytePositionFlag <= flag;
    drvData <= wb;
    drvOe <= !rd;
    // multiplexed host: address strobe latches controls, then the lines change
    if (useAs) begin
      addrStrobeN <= 1'b0;
      repeat (3) @(posedge sys_clk);
      {accessSelectHigh, accessSelectLow} <= ~sel;
      bytePositionFlag <= !flag;
      addrStrobeN <= 1'b1;
    end
    portSelectN <= 1'b0;
    dataStrobeOne <= 1'b0;
    dataStrobeTwo <= 1'b1;
    for (n = 0; n < 40 && hostWaitReady !== 1'b1; n++) @(posedge sys_clk);
    if (hostWaitReady !== 1'b1) timeouts++;
    rb = busWire;
    portSelectN <= 1'b1;
    dataStrobeOne <= !altStrobe;
    dataStrobeTwo <= !altStrobe;
    drvOe <= 1'b0;
    for (n = 0; n < 40 && hostWaitReady !== 1'b0; n++) @(posedge sys_clk);
    if (hostWaitReady !== 1'b0) timeouts++;
  endtask : doByte

  // one word as an unbroken first and second byte pair
  task automatic xfer(input logic [1:0] sel, input logic rd, input logic hiFirst,
                      input logic [15:0] wr, output logic [15:0] rw);
    logic [7:0] b0;
    logic [7:0] b1;
    doByte(sel, rd, 1'b0, hiFirst ? wr[15:8] : wr[7:0], b0);
    doByte(sel, rd, 1'b1, hiFirst ? wr[7:0] : wr[15:8], b1);
    rw = hiFirst ? {b0, b1} : {b1, b0};
  endtask : xfer
endmodule : host_bus_model

`default_nettype wire

// file: verif/tb_host_byte_port_access.sv
// self-checking testbench of the host byte port
`timescale 1ns/100ps
`default_nettype none
`include "hpp_regs.svh"

module tb_host_byte_port_access;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cpuInReset = 1'b0;
  logic [2:0]  regAddr = 3'h0;
  logic [15:0] regWrData = 16'h0;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  wire  [15:0] regRdData;
  wire  [7:0]  busWire, hostByteBusOut, drvData;
  wire         hostByteBusOe, drvOe, flag, selLow, selHigh, rw, selN, ds1, ds2, asN;
  wire         hostWaitReady, hostIrqOut, cpuIrq;
  int          failures = 0;
  int          total_checks = 0;
  logic [15:0] w;

  always #2.5 sys_clk = !sys_clk;
  // resolved bus, a toggling pattern when nobody drives
  assign busWire = drvOe ? drvData : (hostByteBusOe ? hostByteBusOut : 8'h5a ^ {8{sys_clk}});

  host_byte_port_access host_byte_port_access_i (
    .sys_clk, .rstn, .hostByteBusIn(busWire), .hostByteBusOut, .hostByteBusOe,
    .bytePositionFlag(flag), .accessSelectLow(selLow), .accessSelectHigh(selHigh),
    .hostReadWriteSel(rw), .addrStrobeN(asN), .portSelectN(selN), .dataStrobeOne(ds1),
    .dataStrobeTwo(ds2), .hostWaitReady, .hostIrqOut, .cpuInReset, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .cpuIrq
  );
  host_bus_model host_bus_model_i (
    .sys_clk, .busWire, .hostWaitReady, .drvData, .drvOe, .bytePositionFlag(flag),
    .accessSelectLow(selLow), .accessSelectHigh(selHigh), .hostReadWriteSel(rw),
    .portSelectN(selN), .dataStrobeOne(ds1), .dataStrobeTwo(ds2), .addrStrobeN(asN)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    failures += host_bus_model_i.timeouts;
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // register port: one-cycle strobes, read data in the following cycle
  task automatic regWr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask : regRd

  task automatic memRd(input logic [15:0] a, output logic [15:0] d);
    regWr(`REG_CPU_ADDR, a);
    repeat (3) @(posedge sys_clk);
    regRd(`REG_CPU_RDATA, d);
  endtask : memRd

  task automatic hx(input logic [1:0] s, input logic r, input logic h, input logic [15:0] d);
    host_bus_model_i.xfer(s, r, h, d, w);
    if (host_bus_model_i.timeouts != 0) summarize();
  endtask : hx

  task automatic test_ptr_data;
    hx(`SEL_PTR, 1'b0, 1'b0, 16'h0010);
    hx(`SEL_DATA, 1'b0, 1'b0, 16'ha55a);
    memRd(16'h0010, w);
    chk(w, 16'ha55a);
    hx(`SEL_DATA, 1'b1, 1'b0, 16'h0);
    chk(w, 16'ha55a);
    hx(`SEL_PTR, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h0010);
    $display("test_ptr_data done");
  endtask : test_ptr_data

  task automatic test_addr_strobe;
    host_bus_model_i.useAs = 1'b1;
    hx(`SEL_PTR, 1'b0, 1'b0, 16'h0040);
    hx(`SEL_PTR, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h0040);
    host_bus_model_i.useAs = 1'b0;
    hx(`SEL_PTR, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h0040);
    $display("test_addr_strobe done");
  endtask : test_addr_strobe

  task automatic test_autoinc;
    host_bus_model_i.altStrobe = 1'b1;
    hx(`SEL_PTR, 1'b0, 1'b0, 16'h0020);
    hx(`SEL_DATA_INC, 1'b0, 1'b0, 16'h1111);
    hx(`SEL_DATA_INC, 1'b0, 1'b0, 16'h2222);
    memRd(16'h0022, w);
    chk(w, 16'h2222);
    hx(`SEL_PTR, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h0022);
    hx(`SEL_PTR, 1'b0, 1'b0, 16'h0021);
    hx(`SEL_DATA_INC, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h1111);
    hx(`SEL_DATA_INC, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h2222);
    hx(`SEL_PTR, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h0023);
    host_bus_model_i.altStrobe = 1'b0;
    $display("test_autoinc done");
  endtask : test_autoinc

  task automatic test_byte_order;
    regWr(`REG_CTRL, 16'h0001);
    regWr(`REG_CPU_ADDR, 16'h0030);
    regWr(`REG_CPU_WDATA, 16'h1234);
    repeat (3) @(posedge sys_clk);
    hx(`SEL_PTR, 1'b0, 1'b1, 16'h0030);
    hx(`SEL_DATA, 1'b1, 1'b1, 16'h0);
    chk(w, 16'h1234);
    regWr(`REG_CTRL, 16'h0000);
    hx(`SEL_DATA, 1'b1, 1'b0, 16'h0);
    chk(w, 16'h1234);
    $display("test_byte_order done");
  endtask : test_byte_order

  task automatic test_irq;
    regWr(`REG_IRQ_CLEAR, 16'h0003);
    regWr(`REG_IRQ_ENABLE, 16'h0001);
    regWr(3'h7, 16'hffff);
    regRd(3'h7, w);
    chk(w, 16'h0000);
    hx(`SEL_CTRL, 1'b0, 1'b0, 16'h0002);
    repeat (2) @(posedge sys_clk);
    chk({15'h0, cpuIrq}, 16'h0001);
    regRd(`REG_IRQ_STATUS, w);
    chk(w, 16'h0001);
    regWr(`REG_IRQ_ENABLE, 16'h0000);
    repeat (2) @(posedge sys_clk);
    chk({15'h0, cpuIrq}, 16'h0000);
    regWr(`REG_IRQ_CLEAR, 16'h0001);
    regRd(`REG_IRQ_STATUS, w);
    chk(w, 16'h0000);
    regWr(`REG_CTRL, 16'h0004);
    regRd(`REG_CTRL, w);
    chk(w, 16'h0004);
    repeat (5) @(posedge sys_clk);
    chk({15'h0, hostIrqOut}, 16'h0001);
    hx(`SEL_CTRL, 1'b0, 1'b0, 16'h0004);
    repeat (5) @(posedge sys_clk);
    chk({15'h0, hostIrqOut}, 16'h0000);
    $display("test_irq done");
  endtask : test_irq

  task automatic test_cpu_reset;
    cpuInReset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({15'h0, hostIrqOut}, 16'h0001);
    cpuInReset <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({15'h0, hostIrqOut}, 16'h0000);
    $display("test_cpu_reset done");
  endtask : test_cpu_reset

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    regRd(`REG_CTRL, w);
    chk(w, 16'h0000);
    test_ptr_data();
    test_autoinc();
    test_byte_order();
    test_irq();
    test_cpu_reset();
    test_addr_strobe();
    summarize();
  end

  // hang guard
  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    summarize();
  end
endmodule : tb_host_byte_port_access

`default_nettype wire
